// ### hw/tcs_top.sv
// Timer channel sync controller: start, stop, sync set/clear, two complementary pairs
// Summary of operation
// - One sync-start write starts every selected channel on one cycle
// - Group A start bits for channels 0 to 2 start together
// - Sync set/clear only within group A (0-4,9) or group B (6,7)
// - Channel 5 never joins a sync set or clear
// - Sync-select A and B pick which channels join their group
// - Start A runs group A, start B group B; sync-start spans both
// - Sync-start can start channels 3/4 with channels 6/7
// - A clear on the same cycle as overflow wins; no overflow flag
// - Writing 1Bh to sync-start starts channels 3, 4, 6 and 7
// - Writing 81h to sync-start starts channels 0 and 7
// - Zero start bits in start A or B stop those counters
// - Stops through the two start registers are not simultaneous
// - On stop, upper pair counter takes dead time, lower goes to zero
// - Write to compare D of channel 4 or 7 arms that pair's transfer
// - Buffered duties move to compare registers at the trough
// - Phase duties U, V, W come from the three duty buffers
// - Positive phase low on up match, high on down match; negative opposite
// - Complementary outputs idle high, active low
// - Enabled channel 4 underflow pulse fires at every underflow
// - Both pairs together give six complementary phases
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [`TCS_AW-1:0] addr_i,
    input wire logic [`TCS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`TCS_DW-1:0] rdata_o,
    // Complementary PWM outputs, phases U,V,W of pair 0 then pair 1
    output logic [5:0] pwm_pos_o,
    output logic [5:0] pwm_neg_o,
    // Underflow pulses
    output logic ch4_underflow_irq_o,
    output logic ch7_underflow_irq_o,
    // Channel running state
    output tcs_pkg::tcs_chmask_t run_o
);
    import tcs_pkg::*;

    // All state in one word
    typedef struct packed {
        tcs_chmask_t run;
        tcs_chmask_t sel;
        logic [3:0] mode;
        logic [17:0] status;
        tcs_word_t dead_a;
        tcs_word_t dead_b;
        logic [`TCS_NCH-1:0][15:0] cnt;
        logic [`TCS_NCH-1:0][15:0] cmpa;
        logic [`TCS_DW-1:0] rdata;
        logic irq4;
        logic irq7;
    } tcs_state_t;

    tcs_state_t st;
    tcs_state_t next_st;

    // One bundle per pair
    tcs_pair_if pif0 ();
    tcs_pair_if pif1 ();

    // Decoded register strobes
    logic wr_start_a;
    logic wr_start_b;
    logic wr_sync;
    logic wr_cnt;
    logic wr_cmpa;

    // Address fields
    logic [3:0] ch_idx;
    logic idx_ok;
    logic [1:0] region;
    logic pair_sel;
    logic [2:0] pair_slot;

    // Sync clear
    tcs_chmask_t comp_ch;
    tcs_chmask_t clr_src;
    tcs_chmask_t clr;
    logic clr_grp_a;
    logic clr_grp_b;

    // Address slices
    assign region = addr_i[7:6];
    assign ch_idx = addr_i[5:2];
    assign idx_ok = (ch_idx < 4'(`TCS_NCH));
    assign pair_sel = addr_i[5];
    assign pair_slot = addr_i[4:2];

    // Strobes
    assign wr_start_a = wr_i && (addr_i == `TCS_OFF_START_A);
    assign wr_start_b = wr_i && (addr_i == `TCS_OFF_START_B);
    assign wr_sync = wr_i && (addr_i == `TCS_OFF_SYNC_START);

    // Index 10 and up is ignored
    assign wr_cnt = wr_i && (region == `TCS_REGION_CNT) && idx_ok;
    assign wr_cmpa = wr_i && (region == `TCS_REGION_CMPA) && idx_ok;

    // Channels owned by an enabled complementary pair
    always_comb begin
        comp_ch = '0;
        // Pair 0 channels
        comp_ch[3] = st.mode[`TCS_MODE_PAIR0];
        comp_ch[4] = st.mode[`TCS_MODE_PAIR0];
        // Pair 1 channels
        comp_ch[6] = st.mode[`TCS_MODE_PAIR1];
        comp_ch[7] = st.mode[`TCS_MODE_PAIR1];
    end

    // Clear sources: a running plain channel matching a nonzero compare A.
    // Pair channels are left out of sync clear since it upsets the up/down walk.
    always_comb begin
        // Zero compare A: no clear
        for (int c = 0; c < `TCS_NCH; c++) begin
            clr_src[c] = st.run[c] && !comp_ch[c] && (st.cmpa[c] != `TCS_CNT_RST)
                && (st.cnt[c] == st.cmpa[c]);
        end
    end

    // A selected source clears every selected member of its own group
    assign clr_grp_a = |(clr_src & st.sel & `TCS_GRP_A_MASK);
    assign clr_grp_b = |(clr_src & st.sel & `TCS_GRP_B_MASK);

    // Own source plus group clears
    assign clr = (clr_src | (st.sel & `TCS_GRP_A_MASK & {`TCS_NCH{clr_grp_a}})
        | (st.sel & `TCS_GRP_B_MASK & {`TCS_NCH{clr_grp_b}})) & ~comp_ch;

    // Pair 0 is channels 3/4, pair 1 is channels 6/7
    assign pif0.run = st.run[3] && st.run[4];
    assign pif0.limit = st.cmpa[3];
    assign pif0.dead = st.dead_a;
    assign pif0.buf_data = wdata_i[15:0];

    // Pair 1 from group B
    assign pif1.run = st.run[6] && st.run[7];
    assign pif1.limit = st.cmpa[6];
    assign pif1.dead = st.dead_b;
    assign pif1.buf_data = wdata_i[15:0];

    // Duty buffer slots U,V,W and the compare D arming write
    always_comb begin
        pif0.buf_wr = '0;
        pif1.buf_wr = '0;
        pif0.arm = 1'b0;
        pif1.arm = 1'b0;

        if (wr_i && (region == `TCS_REGION_PAIR)) begin
            // Slots 0-2: U, V, W
            for (int i = 0; i < 3; i++) begin
                if (pair_slot == 3'(i)) begin
                    pif0.buf_wr[i] = !pair_sel;
                    pif1.buf_wr[i] = pair_sel;
                end
            end
            // Compare D arms
            if (pair_slot == `TCS_PAIR_SLOT_D) begin
                pif0.arm = !pair_sel;
                pif1.arm = pair_sel;
            end
        end
    end

    // Channels 3 and 4
    tcs_pair u_pair0 (
        .clock_i (clock_i),
        .rstn_i (rstn_i),
        .pif (pif0.pair)
    );

    // Channels 6 and 7
    tcs_pair u_pair1 (
        .clock_i (clock_i),
        .rstn_i (rstn_i),
        .pif (pif1.pair)
    );

    // Next-state logic for run bits, counters, flags and read data
    always_comb begin
        tcs_chmask_t grp;
        tcs_chmask_t wmask;

        grp = '0;
        wmask = '0;
        next_st = st;
        // Pulses follow underflow
        next_st.irq4 = pif0.underflow && st.mode[`TCS_MODE_IRQ4];
        next_st.irq7 = pif1.underflow && st.mode[`TCS_MODE_IRQ7];

        // Start registers: start A writes group A's run bits plus channel 5, start B only group B's
        if (wr_start_a) begin
            wmask = `TCS_START_A_MASK;
            next_st.run = (st.run & ~wmask) | (wdata_i[9:0] & wmask);
        end
        if (wr_start_b) begin
            wmask = `TCS_GRP_B_MASK;
            next_st.run = (st.run & ~wmask) | (wdata_i[9:0] & wmask);
        end

        // Sync start only sets bits; both groups leave on the same edge
        if (wr_sync) begin
            next_st.run = st.run | tcs_sync_map(wdata_i[7:0]);
        end

        // Channel 5 has no select bit, so it never joins a group
        if (wr_i && (addr_i == `TCS_OFF_SEL_A)) begin
            wmask = `TCS_GRP_A_MASK;
            next_st.sel = (st.sel & ~wmask) | (wdata_i[9:0] & wmask);
        end
        if (wr_i && (addr_i == `TCS_OFF_SEL_B)) begin
            wmask = `TCS_GRP_B_MASK;
            next_st.sel = (st.sel & ~wmask) | (wdata_i[9:0] & wmask);
        end

        // Pair and pulse enables
        if (wr_i && (addr_i == `TCS_OFF_MODE)) begin
            next_st.mode = wdata_i[3:0];
        end

        // Dead times
        if (wr_i && (addr_i == `TCS_OFF_DEAD_A)) begin
            next_st.dead_a = wdata_i[15:0];
        end
        if (wr_i && (addr_i == `TCS_OFF_DEAD_B)) begin
            next_st.dead_b = wdata_i[15:0];
        end

        // Clear point or pair limit
        if (wr_cmpa) begin
            next_st.cmpa[ch_idx] = wdata_i[15:0];
        end

        // Status clears by writing ones; a set in the same cycle wins below
        if (wr_i && (addr_i == `TCS_OFF_STATUS)) begin
            next_st.status = st.status & ~wdata_i[17:0];
        end

        // Counter write: a selected channel sets its whole selected group
        if (wr_cnt) begin
            grp[ch_idx] = 1'b1;
            if (st.sel[ch_idx]) begin
                grp = tcs_group_of(int'(ch_idx)) & st.sel;
            end
        end

        // Write, then clear, then count
        for (int c = 0; c < `TCS_NCH; c++) begin
            if (grp[c] && !comp_ch[c]) begin
                next_st.cnt[c] = wdata_i[15:0];
            end else if (clr[c]) begin
                next_st.cnt[c] = `TCS_CNT_RST;
            end else if (st.run[c] && !comp_ch[c]) begin
                next_st.cnt[c] = st.cnt[c] + 16'h0001;
                if (st.cnt[c] == `TCS_CNT_MAX) begin
                    next_st.status[c] = 1'b1;
                end
            end
        end

        // Pair counters are owned by the pair logic while its mode is on
        if (st.mode[`TCS_MODE_PAIR0]) begin
            next_st.cnt[3] = pif0.cnt_u;
            next_st.cnt[4] = pif0.cnt_l;
        end

        if (st.mode[`TCS_MODE_PAIR1]) begin
            next_st.cnt[6] = pif1.cnt_u;
            next_st.cnt[7] = pif1.cnt_l;
        end

        // Flags hold until cleared
        if (pif0.underflow) begin
            next_st.status[`TCS_STAT_UDF0] = 1'b1;
        end
        if (pif1.underflow) begin
            next_st.status[`TCS_STAT_UDF1] = 1'b1;
        end

        // Read data stands for exactly the cycle after the strobe
        next_st.rdata = '0;
        if (rd_i) begin
            unique case (region)
                // Sync start reads zero
                2'h0: begin
                    unique case (addr_i)
                        `TCS_OFF_START_A: next_st.rdata = 32'(st.run & `TCS_START_A_MASK);
                        `TCS_OFF_START_B: next_st.rdata = 32'(st.run & `TCS_GRP_B_MASK);
                        `TCS_OFF_SEL_A: next_st.rdata = 32'(st.sel & `TCS_GRP_A_MASK);
                        `TCS_OFF_SEL_B: next_st.rdata = 32'(st.sel & `TCS_GRP_B_MASK);
                        `TCS_OFF_MODE: next_st.rdata = 32'(st.mode);
                        `TCS_OFF_STATUS: next_st.rdata = 32'(st.status);
                        `TCS_OFF_DEAD_A: next_st.rdata = 32'(st.dead_a);
                        `TCS_OFF_DEAD_B: next_st.rdata = 32'(st.dead_b);
                        default: next_st.rdata = '0;
                    endcase
                end
                // Pair counters lag a cycle
                `TCS_REGION_CNT: begin
                    if (idx_ok) begin
                        next_st.rdata = 32'(st.cnt[ch_idx]);
                    end
                end
                `TCS_REGION_CMPA: begin
                    if (idx_ok) begin
                        next_st.rdata = 32'(st.cmpa[ch_idx]);
                    end
                end
                `TCS_REGION_PAIR: next_st.rdata = '0; // Duty buffers are write only
            endcase
        end
    end

    // State register
    // Reset stops every channel
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs; six phases come from the two pairs side by side
    assign rdata_o = st.rdata;

    // Phases from pair flip-flops
    assign pwm_pos_o = {pif1.pos, pif0.pos};
    assign pwm_neg_o = {pif1.neg, pif0.neg};
    // One-cycle pulses
    assign ch4_underflow_irq_o = st.irq4;
    assign ch7_underflow_irq_o = st.irq7;
    assign run_o = st.run;
endmodule // tcs_top

// ### hw/tcs_defs.svh
// Register offsets, field positions, reset values and masks of the timer sync block
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
`define TCS_NCH 10
`define TCS_CW 16
`define TCS_AW 8
`define TCS_DW 32
`define TCS_OFF_START_A 8'h00
`define TCS_OFF_START_B 8'h04
`define TCS_OFF_SYNC_START 8'h08
`define TCS_OFF_SEL_A 8'h0c
`define TCS_OFF_SEL_B 8'h10
`define TCS_OFF_MODE 8'h14
`define TCS_OFF_STATUS 8'h18
`define TCS_OFF_DEAD_A 8'h1c
`define TCS_OFF_DEAD_B 8'h20
`define TCS_REGION_CNT 2'h1
`define TCS_REGION_CMPA 2'h2
`define TCS_REGION_PAIR 2'h3
`define TCS_PAIR_SLOT_D 3'h3
`define TCS_GRP_A_MASK 10'h21f
`define TCS_GRP_B_MASK 10'h0c0
`define TCS_START_A_MASK 10'h23f
`define TCS_MODE_PAIR0 0
`define TCS_MODE_PAIR1 1
`define TCS_MODE_IRQ4 2
`define TCS_MODE_IRQ7 3
`define TCS_STAT_UDF0 16
`define TCS_STAT_UDF1 17
`define TCS_CNT_MAX 16'hffff
`define TCS_CNT_RST 16'h0000
`define TCS_OUT_IDLE 3'h7
`endif

// ### hw/tcs_pkg.sv
// Types and decode functions shared by the timer sync block
package tcs_pkg;
`include "tcs_defs.svh"
    typedef logic [`TCS_CW-1:0] tcs_word_t;
    typedef logic [`TCS_NCH-1:0] tcs_chmask_t;
    typedef enum logic [0:0] {
        TCS_DIR_UP = 1'b0,
        TCS_DIR_DOWN = 1'b1
    } tcs_dir_t;

    // Sync-start byte: bit 7 is channel 0, bit 0 is channel 7
    function automatic tcs_chmask_t tcs_sync_map(input logic [7:0] v);
        tcs_chmask_t m;
        m = '0;
        m[0] = v[7];
        m[1] = v[6];
        m[2] = v[5];
        m[3] = v[4];
        m[4] = v[3];
        m[9] = v[2];
        m[6] = v[1];
        m[7] = v[0];
        return m;
    endfunction

    // Channels that share a sync group with channel c (channel 5 has none)
    function automatic tcs_chmask_t tcs_group_of(input int c);
        tcs_chmask_t a;
        tcs_chmask_t b;
        a = `TCS_GRP_A_MASK;
        b = `TCS_GRP_B_MASK;
        if (a[c]) begin
            return a;
        end
        if (b[c]) begin
            return b;
        end
        return '0;
    endfunction
endpackage

// ### hw/tcs_pair_if.sv
// Signals between the sync controller and one complementary PWM pair
`timescale 1ns/1ps
interface tcs_pair_if;
    logic run;
    logic [15:0] limit;
    logic [15:0] dead;
    logic [2:0] buf_wr;
    logic [15:0] buf_data;
    logic arm;
    logic [15:0] cnt_u;
    logic [15:0] cnt_l;
    logic underflow;
    logic [2:0] pos;
    logic [2:0] neg;
    modport ctrl (output run, limit, dead, buf_wr, buf_data, arm,
                  input cnt_u, cnt_l, underflow, pos, neg);
    modport pair (input run, limit, dead, buf_wr, buf_data, arm,
                  output cnt_u, cnt_l, underflow, pos, neg);
endinterface

// ### hw/tcs_pair.sv
// One complementary PWM channel pair: up/down counter, trough transfer, three phases
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_pair (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Controller side
    tcs_pair_if.pair pif
);
    import tcs_pkg::*;

    typedef struct packed {
        tcs_word_t l;
        tcs_word_t u;
        tcs_dir_t dir;
        logic [2:0][15:0] bufr;
        logic [2:0][15:0] cmp;
        logic armed;
        logic udf;
        logic [2:0] pos;
        logic [2:0] neg;
    } tcs_pair_st_t;

    tcs_pair_st_t st;
    tcs_pair_st_t next_st;

    assign pif.cnt_u = st.u;
    assign pif.cnt_l = st.l;
    assign pif.underflow = st.udf;
    assign pif.pos = st.pos;
    assign pif.neg = st.neg;

    // Counter walk, buffer transfer at the trough and phase edges
    always_comb begin
        next_st = st;
        next_st.udf = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (pif.buf_wr[i]) begin
                next_st.bufr[i] = pif.buf_data;
            end
        end
        if (pif.arm) begin
            next_st.armed = 1'b1;
        end
        if (!pif.run) begin
            next_st.l = `TCS_CNT_RST;
            next_st.u = pif.dead;
            next_st.dir = TCS_DIR_UP;
            next_st.pos = `TCS_OUT_IDLE;
            next_st.neg = `TCS_OUT_IDLE;
        end else begin
            // Active low: up match drives positive low, down match drives it high
            for (int i = 0; i < 3; i++) begin
                if (st.l == st.cmp[i]) begin
                    next_st.pos[i] = (st.dir == TCS_DIR_DOWN);
                    next_st.neg[i] = (st.dir == TCS_DIR_UP);
                end
            end
            if (st.dir == TCS_DIR_UP) begin
                if (st.u >= pif.limit) begin
                    next_st.dir = TCS_DIR_DOWN;
                    next_st.l = st.l - 16'h0001;
                end else begin
                    next_st.l = st.l + 16'h0001;
                end
            end else if (st.l == `TCS_CNT_RST) begin
                // Trough: underflow, and the armed buffers move to compare
                next_st.udf = 1'b1;
                next_st.dir = TCS_DIR_UP;
                next_st.l = st.l + 16'h0001;
                if (st.armed || pif.arm) begin
                    next_st.cmp = st.bufr;
                    next_st.armed = 1'b0;
                end
            end else begin
                next_st.l = st.l - 16'h0001;
            end
            next_st.u = next_st.l + pif.dead;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{dir: TCS_DIR_UP, pos: `TCS_OUT_IDLE, neg: `TCS_OUT_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end
endmodule // tcs_pair

// ### verif/tcs_top_sva.sv
// Port-level assertions for the timer sync controller
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_top_sva (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [`TCS_AW-1:0] addr_i,
    input wire logic [`TCS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`TCS_DW-1:0] rdata_o,
    // Watched outputs
    input wire logic [5:0] pwm_pos_o,
    input wire logic [5:0] pwm_neg_o,
    input wire logic ch4_underflow_irq_o,
    input wire logic ch7_underflow_irq_o,
    input wire tcs_pkg::tcs_chmask_t run_o
);
    import tcs_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Sync-start strobes that start channels, and a stopped pair 0
    sequence s_sync(v);
        wr_i && addr_i == `TCS_OFF_SYNC_START && wdata_i[7:0] == v;
    endsequence
    sequence s_sync_any;
        wr_i && addr_i == `TCS_OFF_SYNC_START;
    endsequence
    sequence s_pair0_stopped;
        (!run_o[3] || !run_o[4]) [*3];
    endsequence
    property p_sync_1b;
        s_sync(8'h1b) |=> (run_o & 10'h0d8) == 10'h0d8;
    endproperty
    a_sync_1b: assert property (p_sync_1b) else $error("1b did not start 3,4,6,7");
    property p_sync_81;
        s_sync(8'h81) |=> run_o[0] && run_o[7];
    endproperty
    a_sync_81: assert property (p_sync_81) else $error("81 did not start 0 and 7");
    property p_sync_keep;
        s_sync_any |=> (run_o & $past(run_o)) == $past(run_o);
    endproperty
    a_sync_keep: assert property (p_sync_keep) else $error("sync start stopped a channel");
    property p_ch5_alone;
        $changed(run_o[5]) |-> $past(wr_i) && $past(addr_i) == `TCS_OFF_START_A;
    endproperty
    a_ch5_alone: assert property (p_ch5_alone) else $error("channel 5 moved without start A");
    property p_grp_b_rise;
        $rose(run_o[6]) || $rose(run_o[7]) |-> $past(wr_i) &&
            ($past(addr_i) == `TCS_OFF_START_B || $past(addr_i) == `TCS_OFF_SYNC_START);
    endproperty
    a_grp_b_rise: assert property (p_grp_b_rise) else $error("group B started by wrong reg");
    property p_stop_a;
        wr_i && addr_i == `TCS_OFF_START_A && !wdata_i[3] && !wdata_i[4] |=> !run_o[3] && !run_o[4];
    endproperty
    a_stop_a: assert property (p_stop_a) else $error("channels 3/4 kept running");
    property p_stop_b;
        wr_i && addr_i == `TCS_OFF_START_B && !wdata_i[6] && !wdata_i[7] |=> !run_o[6] && !run_o[7];
    endproperty
    a_stop_b: assert property (p_stop_b) else $error("channels 6/7 kept running");
    property p_phase_excl;
        (pwm_pos_o | pwm_neg_o) == 6'h3f;
    endproperty
    a_phase_excl: assert property (p_phase_excl) else $error("both phases active");
    property p_idle_stop;
        s_pair0_stopped |-> pwm_pos_o[2:0] == 3'h7 && pwm_neg_o[2:0] == 3'h7;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("stopped pair not idle high");
    property p_irq_pulse;
        ch4_underflow_irq_o |=> !ch4_underflow_irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("underflow pulse too long");
    property p_irq_run;
        ch7_underflow_irq_o |-> $past(run_o[6]) && $past(run_o[7]);
    endproperty
    a_irq_run: assert property (p_irq_run) else $error("underflow on idle pair");
    property p_rd_idle;
        !rd_i |=> rdata_o == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule // tcs_top_sva
bind tcs_top tcs_top_sva tcs_top_sva_i (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_pos_o(pwm_pos_o),
    .pwm_neg_o(pwm_neg_o), .ch4_underflow_irq_o(ch4_underflow_irq_o),
    .ch7_underflow_irq_o(ch7_underflow_irq_o), .run_o(run_o));

// ### verif/timer_channel_sync_control_tb.sv
// Self-checking bench for the timer channel sync controller
`timescale 1ns/1ps
`include "tcs_defs.svh"
module timer_channel_sync_control_tb;
    import tcs_pkg::*;
    // Design ports
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [`TCS_AW-1:0] addr_i = '0;
    logic [`TCS_DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [`TCS_DW-1:0] rdata_o;
    logic [5:0] pwm_pos_o;
    logic [5:0] pwm_neg_o;
    logic ch4_underflow_irq_o;
    logic ch7_underflow_irq_o;
    tcs_chmask_t run_o;
    // Bench state and model
    int mismatches = 0;
    int check_count = 0;
    int seed = 90131;
    int ch_of[8] = '{7, 6, 9, 4, 3, 2, 1, 0};
    logic [7:0] adr_tab[4] = '{`TCS_OFF_START_A, `TCS_OFF_START_B, `TCS_OFF_SYNC_START, 8'h3c};
    logic [9:0] m_run = '0;
    logic [31:0] va;
    logic [31:0] vb;
    logic [5:0] low_seen;
    int n4;
    int n7;

    always #50 clock_i = ~clock_i;

    tcs_top tcs_top_i (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_pos_o(pwm_pos_o),
        .pwm_neg_o(pwm_neg_o), .ch4_underflow_irq_o(ch4_underflow_irq_o),
        .ch7_underflow_irq_o(ch7_underflow_irq_o), .run_o(run_o));

    // Compare and tally
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Write cycle; the model follows and run state is compared after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        case (a)
            `TCS_OFF_START_A: m_run = (m_run & ~`TCS_START_A_MASK) | (d[9:0] & `TCS_START_A_MASK);
            `TCS_OFF_START_B: m_run = (m_run & ~`TCS_GRP_B_MASK) | (d[9:0] & `TCS_GRP_B_MASK);
            `TCS_OFF_SYNC_START: for (int b = 0; b < 8; b++) if (d[b]) m_run[ch_of[b]] = 1'b1;
            default: ;
        endcase
        #1;
        chk("run", {22'h0, m_run}, {22'h0, run_o});
    endtask
    // Read cycle; data stands only in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    // Verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 600 cycles of the sequence
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        chk("idle pwm", 32'hfff, {20'h0, pwm_pos_o, pwm_neg_o});
        $display("test reset done");
        // Start A starts channels 0 to 2 together
        wr(`TCS_OFF_START_A, 32'h7);
        rd(8'h40, va);
        rd(8'h44, vb);
        chk("ch1 count", va + 2, vb);
        wr(`TCS_OFF_START_A, 32'h0);
        // Sync start across groups
        wr(`TCS_OFF_SYNC_START, 32'h1b);
        rd(8'h4c, va);
        rd(8'h58, vb);
        chk("ch6 count", va + 2, vb);
        wr(`TCS_OFF_START_A, 32'h0);
        wr(`TCS_OFF_START_B, 32'h0);
        wr(8'h40, 32'h0);
        wr(8'h5c, 32'h0);
        wr(`TCS_OFF_SYNC_START, 32'h81);
        rd(8'h40, va);
        rd(8'h5c, vb);
        chk("ch7 count", va + 2, vb);
        $display("test sync start done");
        // Random mix of start, stop, sync start and an unmapped write
        repeat (40) wr(adr_tab[$unsigned($random(seed)) % 4], $random(seed));
        rd(8'h3c, va);
        chk("unmapped", 32'h0, va);
        rd(`TCS_OFF_SYNC_START, va);
        chk("sync start read", 32'h0, va);
        $display("test random mix done");
        // Group selects ignore channels outside the group
        wr(`TCS_OFF_SEL_A, 32'h3ff);
        rd(`TCS_OFF_SEL_A, va);
        chk("sel a", {22'h0, `TCS_GRP_A_MASK}, va);
        wr(`TCS_OFF_SEL_B, 32'h3ff);
        rd(`TCS_OFF_SEL_B, va);
        chk("sel b", {22'h0, `TCS_GRP_B_MASK}, va);
        // Synchronous set of channels 1 and 2 only
        wr(`TCS_OFF_SEL_A, 32'h6);
        wr(8'h40, 32'h0);
        wr(`TCS_OFF_START_A, 32'h7);
        wr(8'h44, 32'd100);
        rd(8'h44, va);
        rd(8'h48, vb);
        chk("ch2 set", va + 2, vb);
        rd(8'h40, vb);
        chk("ch0 apart", 32'h1, {31'h0, vb < 32'd50});
        $display("test sync set done");
        // Clear at ffff wins over overflow; without clear the flag sets
        for (int k = 0; k < 2; k++) begin
            wr(`TCS_OFF_START_A, 32'h0);
            wr(`TCS_OFF_SEL_A, 32'h0);
            wr(8'h80, k ? 32'h0 : 32'hffff);
            wr(8'h40, 32'hfff0);
            wr(`TCS_OFF_STATUS, 32'hffffffff);
            wr(`TCS_OFF_START_A, 32'h1);
            repeat (40) @(posedge clock_i);
            rd(`TCS_OFF_STATUS, va);
            chk("overflow flag", k, va & 32'h1);
        end
        $display("test overflow done");
        // Both complementary pairs, duties armed, six phases
        wr(`TCS_OFF_START_A, 32'h0);
        wr(`TCS_OFF_START_B, 32'h0);
        wr(`TCS_OFF_SEL_B, 32'h0);
        wr(`TCS_OFF_DEAD_A, 32'd5);
        wr(`TCS_OFF_DEAD_B, 32'd7);
        wr(8'h8c, 32'd20);
        wr(8'h98, 32'd22);
        for (int i = 0; i < 3; i++) begin
            wr(8'(8'hc0 + 4 * i), 8 + 2 * i);
            wr(8'(8'he0 + 4 * i), 8 + 2 * i);
        end
        wr(`TCS_OFF_MODE, 32'hf);
        wr(8'hcc, 32'h1);
        wr(8'hec, 32'h1);
        wr(`TCS_OFF_STATUS, 32'hffffffff);
        wr(`TCS_OFF_SYNC_START, 32'h1b);
        low_seen = '0;
        n4 = 0;
        n7 = 0;
        repeat (300) begin
            @(posedge clock_i);
            #1;
            if (n4 > 0 && n7 > 0) begin
                low_seen = low_seen | ~pwm_pos_o;
            end
            n4 += int'(ch4_underflow_irq_o === 1'b1);
            n7 += int'(ch7_underflow_irq_o === 1'b1);
        end
        chk("phases low", 32'h3f, {26'h0, low_seen});
        chk("ch4 pulses", 32'h1, {31'h0, n4 >= 4});
        chk("ch7 pulses", 32'h1, {31'h0, n7 >= 4});
        rd(`TCS_OFF_STATUS, va);
        chk("underflow flags", 32'h30000, va & 32'h30000);
        // Stop each pair through its own start register
        wr(`TCS_OFF_START_A, 32'h0);
        wr(`TCS_OFF_START_B, 32'h0);
        repeat (3) @(posedge clock_i);
        rd(8'h4c, va);
        chk("ch3 stop", 32'd5, va);
        rd(8'h50, va);
        chk("ch4 stop", 32'h0, va);
        rd(8'h58, va);
        chk("ch6 stop", 32'd7, va);
        rd(8'h5c, va);
        chk("ch7 stop", 32'h0, va);
        chk("stop pwm", 32'hfff, {20'h0, pwm_pos_o, pwm_neg_o});
        $display("test complementary done");
        test_done();
    end
endmodule // timer_channel_sync_control_tb
